/* bus_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_ctl
(
    input  wire logic                       clock_in,
    input  wire logic                       arst_n_in,
    input  wire logic                       enable_in,
    input  wire bus_ctl_pkg::bus_in_t       bus_in,
    input  wire logic                       cpu_cycle_req_in,
    input  wire logic                       cpu_cycle_done_in,
    input  wire logic                       addr_phase_in,
    input  wire logic [1:0]                 ext_addr_in,
    input  wire logic                       err_data_in,
    input  wire logic                       err_enable_in,
    input  wire logic                       run_in,
    output var  logic                       dma_grant_out_n_out,
    output var  logic                       sync_strobe_n_out,
    output var  logic                       ext_addr_line_a_n_out,
    output var  logic                       ext_addr_line_b_n_out,
    output var  logic                       ext_addr_oe_out,
    output var  logic                       run_state_indicator_out,
    output var  logic                       console_mode_out,
    output var  logic                       cpu_owns_bus_out,
    output var  logic [1:0]                 irq_pending_out,
    output var  bus_ctl_pkg::refresh_evt_t  refresh_out
);
    import bus_ctl_pkg::*;

    // ------------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------------
    arb_state_t state_r;
    arb_state_t state_nxt;
    logic       req;
    logic       sack;
    logic       halted;
    logic       cpu_busy;

    assign req      = !bus_in.req_n;   // R14
    assign sack     = !bus_in.sack_n;  // R14
    assign cpu_busy = !sync_strobe_n_out;

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_CPU_OWNS:  if (req) state_nxt = ST_WAIT_IDLE;          // R4
            ST_WAIT_IDLE:
                if (!req) state_nxt = ST_CPU_OWNS;
                else if (!cpu_busy && !cpu_cycle_req_in)
                    state_nxt = ST_GRANTED;                          // R5
            ST_GRANTED:
                if (sack) state_nxt = ST_DMA_OWNS;                   // R6 R13
                else if (!req) state_nxt = ST_CPU_OWNS;
            ST_DMA_OWNS:  if (!sack) state_nxt = ST_CPU_OWNS;        // R13
            default:      state_nxt = ST_CPU_OWNS;
        endcase
    end

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            state_r <= ST_CPU_OWNS;
        else if (enable_in)
            state_r <= state_nxt;
    end

    // ------------------------------------------------------------------
    // own bus cycle strobe
    // ------------------------------------------------------------------
    logic sync_nxt;
    logic grant_nxt;

    assign sync_nxt = sync_strobe_n_out
        ? !(cpu_cycle_req_in && state_r == ST_CPU_OWNS && !halted)
        : cpu_cycle_done_in;                                         // R5
    assign grant_nxt = !(state_nxt == ST_GRANTED);                   // R5

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            sync_strobe_n_out   <= 1'b1;
            dma_grant_out_n_out <= 1'b1;
            cpu_owns_bus_out    <= 1'b1;
        end
        else if (enable_in)
        begin
            sync_strobe_n_out   <= sync_nxt;
            dma_grant_out_n_out <= grant_nxt || !sync_nxt;           // R5
            cpu_owns_bus_out    <= (state_nxt == ST_CPU_OWNS);
        end
    end

    // ------------------------------------------------------------------
    // extended address lines
    // ------------------------------------------------------------------
    logic drive_ext;
    assign drive_ext = !sync_nxt;

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            ext_addr_line_a_n_out <= 1'b1;
            ext_addr_line_b_n_out <= 1'b1;
            ext_addr_oe_out       <= 1'b0;
        end
        else if (enable_in)
        begin
            ext_addr_oe_out       <= drive_ext;
            ext_addr_line_a_n_out <= addr_phase_in ? !ext_addr_in[0]
                                                   : !err_data_in;   // R3
            ext_addr_line_b_n_out <= addr_phase_in ? !ext_addr_in[1]
                                                   : !err_enable_in; // R3
        end
    end

    // ------------------------------------------------------------------
    // halt, run, interrupts, refresh
    // ------------------------------------------------------------------
    halt_timer u_halt
    (
        .clock_in   (clock_in),
        .arst_n_in  (arst_n_in),
        .enable_in  (enable_in),
        .halt_n_in  (bus_in.halt_n),
        .halted_out (halted)
    );

    logic refr;
    logic xact;
    assign refr = !bus_in.refresh_n;
    assign xact = !bus_in.sync_n && !bus_in.din_n;

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            console_mode_out        <= 1'b0;
            run_state_indicator_out <= 1'b0;
            irq_pending_out         <= 2'h0;
            refresh_out             <= '0;
        end
        else if (enable_in)
        begin
            console_mode_out        <= halted;                            // R7
            run_state_indicator_out <= run_in && !halted;                 // R12
            irq_pending_out         <= {!bus_in.irq6_n, !bus_in.irq5_n}; // R1 R2
            refresh_out.refresh_pulse <= refr && xact && !sack;           // R8
            refresh_out.block_mode    <= refr && sack;                    // R9
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_grant_needs_idle: assert property (@(posedge clock_in) // R5
        disable iff (!arst_n_in)
        !dma_grant_out_n_out |-> sync_strobe_n_out)
        else $error("grant while own sync strobe active");

    a_grant_needs_req: assert property (@(posedge clock_in) // R4
        disable iff (!arst_n_in)
        enable_in && $fell(dma_grant_out_n_out) |-> $past(req))
        else $error("grant without request");

    a_grant_cpu_quiet: assert property (@(posedge clock_in) // R5
        disable iff (!arst_n_in)
        $fell(dma_grant_out_n_out) |-> $past(!cpu_cycle_req_in))
        else $error("grant while processor wants the bus");

    a_grant_drop_ack: assert property (@(posedge clock_in) // R4
        disable iff (!arst_n_in)
        enable_in && !dma_grant_out_n_out && sack |=> dma_grant_out_n_out)
        else $error("grant held after acknowledge");

    a_sync_refused: assert property (@(posedge clock_in) // R5
        disable iff (!arst_n_in)
        $fell(sync_strobe_n_out) |-> $past(state_r == ST_CPU_OWNS && !halted))
        else $error("own cycle started without bus ownership");

    a_irq_follow: assert property (@(posedge clock_in) // R1
        disable iff (!arst_n_in)
        enable_in |=> irq_pending_out[0] == $past(!bus_in.irq5_n))
        else $error("level five irq not followed");

    a_console_cause: assert property (@(posedge clock_in) // R7
        disable iff (!arst_n_in)
        console_mode_out |-> $past(!bus_in.halt_n, 2))
        else $error("console mode without halt");
endmodule
`default_nettype wire

/* bus_ctl_pkg.sv */
// Summary of operation
// R1 - option module pulls level-five interrupt line low to request service
// R2 - option module pulls level-six interrupt line low to request service
// R3 - lines 16/17 carry address bits in address phase, error data/enable later
// R4 - processor arbitrates mastership between itself and every requesting module
// R5 - grant only after own cycle ends and while own sync strobe is released
// R6 - granted module drops its request and asserts selection acknowledge
// R7 - halt line held low 25 us or more puts processor in console mode
// R8 - while refresh line is low, memories refresh on each sync/data-in cycle; the code gives no refresh pulse while selection acknowledge is asserted
// R9 - refresh line also marks block-mode transfers
// R10 - dma refresh must complete a full sequence every 1.6 ms
// R11 - dma masters should avoid long bursts that postpone refresh
// R12 - processor in top slot may drive a spare pin showing run state
// R13 - selection acknowledge from the module means it now holds mastership
// R14 - low-suffix bus lines are active low, released high by termination
package bus_ctl_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS  = 20000;
    localparam int HALT_TIME_NS   = 25000;
    localparam int HALT_CYCLES    = (HALT_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                    / CLK_PERIOD_PS;
    localparam int HALT_CNT_W     = 12;

    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_CPU_OWNS  = 4'b0001,
        ST_WAIT_IDLE = 4'b0010,
        ST_GRANTED   = 4'b0100,
        ST_DMA_OWNS  = 4'b1000
    } arb_state_t;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic req_n;
        logic sack_n;
        logic sync_n;
        logic din_n;
        logic refresh_n;
        logic halt_n;
        logic irq5_n;
        logic irq6_n;
    } bus_in_t;

    typedef struct packed {
        logic addr_phase;
        logic err_data;
        logic err_enable;
        logic [1:0] ext_addr;
    } ext_line_t;

    typedef struct packed {
        logic refresh_pulse;
        logic block_mode;
    } refresh_evt_t;

endpackage

/* bus_ctl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_ctl_tb;
    import bus_ctl_pkg::*;
    logic clock_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic din_n = 1'b1, ref_n = 1'b1, halt_n = 1'b1, i5_n = 1'b1;
    logic i6_n = 1'b1, creq = 1'b0, cdone = 1'b0, aph = 1'b0;
    logic ed = 1'b0, ee = 1'b0, run = 1'b0, want = 1'b0;
    logic en = 1'b1;
    logic [1:0] ea = 2'b00;
    wire logic req_n, sack_n, gnt, sync_o, la, lb, oe, run_o, con, own;
    wire logic [1:0] irq;
    wire refresh_evt_t rf;
    wire bus_in_t bi = {req_n, sack_n, sync_o, din_n, ref_n, halt_n,
                        i5_n, i6_n};
    int n_errors = 0;
    int samples_checked = 0;
    always #10 clock_in = ~clock_in;
    dma_partner peer (.clock_in(clock_in), .want_in(want),
        .grant_n_in(gnt), .req_n_out(req_n), .sack_n_out(sack_n));
    bus_ctl dut
    (
        .clock_in                (clock_in),
        .arst_n_in               (arst_n_in),
        .enable_in               (en),
        .bus_in                  (bi),
        .cpu_cycle_req_in        (creq),
        .cpu_cycle_done_in       (cdone),
        .addr_phase_in           (aph),
        .ext_addr_in             (ea),
        .err_data_in             (ed),
        .err_enable_in           (ee),
        .run_in                  (run),
        .dma_grant_out_n_out     (gnt),
        .sync_strobe_n_out       (sync_o),
        .ext_addr_line_a_n_out   (la),
        .ext_addr_line_b_n_out   (lb),
        .ext_addr_oe_out         (oe),
        .run_state_indicator_out (run_o),
        .console_mode_out        (con),
        .cpu_owns_bus_out        (own),
        .irq_pending_out         (irq),
        .refresh_out             (rf)
    );
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic wait_gnt();
        for (int i = 0; i < 10 && gnt !== 1'b0; i++) cyc(1);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_dma();
        want = 1'b1;
        wait_gnt();
        chk(gnt === 1'b0, "no grant");
        cyc(3);
        chk(own === 1'b0 && gnt === 1'b1 && sack_n === 1'b0, "owner");
        want = 1'b0;
        cyc(3);
        chk(own === 1'b1, "not returned");
        $display("dma handover done");
    endtask
    task automatic t_own_cycle();
        bit seen;
        creq = 1'b1;
        aph = 1'b1;
        ea = 2'b10;
        want = 1'b1;
        cyc(3);
        chk(oe === 1'b1 && la === 1'b1 && lb === 1'b0, "addr");
        chk(sync_o === 1'b0 && gnt === 1'b1, "no own cycle");
        aph = 1'b0;
        ed = 1'b1;
        din_n = 1'b0;
        ref_n = 1'b0;
        seen = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            cyc(1);
            seen |= (rf.refresh_pulse === 1'b1);
        end
        chk(seen, "no refresh");
        chk(la === 1'b0 && lb === 1'b1, "data");
        chk(gnt === 1'b1, "grant in own cycle");
        creq = 1'b0;
        cdone = 1'b1;
        din_n = 1'b1;
        wait_gnt();
        cdone = 1'b0;
        chk(gnt === 1'b0 && sync_o === 1'b1, "grant late");
        cyc(3);
        chk(rf.block_mode === 1'b1, "block");
        want = 1'b0;
        ref_n = 1'b1;
        cyc(3);
        $display("own cycle done");
    endtask
    task automatic t_freeze();
        en = 1'b0;
        i5_n = 1'b0;
        cyc(3);
        chk(irq === 2'b00 && own === 1'b1, "not frozen");
        en = 1'b1;
        cyc(2);
        chk(irq === 2'b01, "not resumed");
        i5_n = 1'b1;
        cyc(2);
        $display("clock enable done");
    endtask
    task automatic t_irq();
        i5_n = 1'b0;
        cyc(3);
        chk(irq === 2'b01, "level five");
        i5_n = 1'b1;
        i6_n = 1'b0;
        cyc(3);
        chk(irq === 2'b10, "level six");
        i6_n = 1'b1;
        $display("interrupt lines done");
    endtask
    task automatic t_halt();
        run = 1'b1;
        cyc(3);
        halt_n = 1'b0;
        cyc(1200);
        chk(con === 1'b0 && run_o === 1'b1, "early halt");
        cyc(60);
        chk(con === 1'b1 && run_o === 1'b0, "no halt");
        halt_n = 1'b1;
        $display("halt done");
    endtask
    initial
    begin
        #100000;
        n_errors++;
        stop_test();
    end
    initial
    begin
        cyc(8);
        chk(gnt === 1'b1 && own === 1'b1 && oe === 1'b0, "reset");
        chk(sync_o === 1'b1 && con === 1'b0, "reset outputs");
        arst_n_in = 1'b1;
        cyc(2);
        t_dma();
        t_own_cycle();
        t_freeze();
        t_irq();
        t_halt();
        stop_test();
    end
endmodule
`default_nettype wire

/* dma_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module dma_partner
(
    input  wire logic clock_in,
    input  wire logic want_in,
    input  wire logic grant_n_in,
    output var  logic req_n_out,
    output var  logic sack_n_out
);
    initial
    begin
        req_n_out  = 1'b1;
        sack_n_out = 1'b1;
    end
    // request until granted, then hold acknowledge while work remains
    always @(posedge clock_in)
    begin
        #1;
        req_n_out  <= !(want_in && sack_n_out && grant_n_in);
        sack_n_out <= !(want_in && (!grant_n_in || !sack_n_out));
    end
endmodule
`default_nettype wire

/* halt_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module halt_timer
#(
    parameter int COUNT = bus_ctl_pkg::HALT_CYCLES
)
(
    input  wire logic clock_in,
    input  wire logic arst_n_in,
    input  wire logic enable_in,
    input  wire logic halt_n_in,
    output var  logic halted_out
);
    import bus_ctl_pkg::*;

    logic [HALT_CNT_W-1:0] count_r;
    logic [HALT_CNT_W-1:0] count_nxt;
    logic                  done;

    assign done      = (count_r == HALT_CNT_W'(COUNT - 1));
    assign count_nxt = halt_n_in ? '0 : (done ? count_r : count_r + 1'b1); // R7

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            count_r    <= '0;
            halted_out <= 1'b0;
        end
        else if (enable_in)
        begin
            count_r    <= count_nxt;
            halted_out <= !halt_n_in && done; // R7
        end
    end

    a_halt_entry: assert property (@(posedge clock_in) // R7
        disable iff (!arst_n_in)
        enable_in && halted_out |-> $past(!halt_n_in))
        else $error("halt asserted without halt request");
endmodule
`default_nettype wire
